//--- hw/dbitc_pkg.sv
// Contract
// - Acknowledge goes low on every chip-selected read or write cycle.
// - Late select against a sampling edge may delay acknowledge by one cycle.
// - One active-low interrupt output, asserted for any enabled one of eight events.
// - Mask register picks which conditions may drive the interrupt output.
// - Reading status returns every currently active condition.
// - Interrupt acknowledge with pending interrupt returns the vector and acknowledges.
// - Discrete pins can act as separate interrupt outputs for channels and counter.
// - Rate generator makes 18 standard rates, 50 to 38.4K baud, from 3.6864 MHz.
// - Every generator output runs at sixteen times its baud rate.
// - Counter divides reference or external clock into a 16X clock.
// - Four selectors pick generator rate, counter or external input independently.
// - Counter always uses the 16-bit preset from upper and lower registers.
// - Timer mode reloads from preset continuously, giving a square wave.
// - Counter mode counts down once from preset, one-shot delay.
// - Time-out mode: receiver activity restarts the counter, expiry signals pause.
// - Counter counts down and sets its status bit on each pass through zero.
// - Counter output selectable onto a pin or as a clock source.
// - Counter takes start, stop, write, preset, read value and time-out commands.
// - Stop command clears counter condition; other sources clear their own conditions.
package dbitc_pkg;
    localparam int unsigned CLK_HZ    = 100_000_000;
    localparam int unsigned REF_HZ    = 3_686_400;
    localparam int unsigned NUM_RATES = 18;
    localparam int unsigned NUM_SEL   = 4;
    localparam int unsigned NUM_SYNC  = 4;

    // 16X divisors of the reference tick, 50 baud up to 38400 baud
    localparam logic [12:0] RATE_DIV [NUM_RATES] = '{
        13'h1200, 13'h0c00, 13'h082f, 13'h06b1, 13'h0600, 13'h0480,
        13'h0300, 13'h0180, 13'h00db, 13'h00c0, 13'h0080, 13'h0073,
        13'h0060, 13'h0030, 13'h0020, 13'h0018, 13'h000c, 13'h0006};

    localparam logic [4:0] SEL_CT  = 5'h12;
    localparam logic [4:0] SEL_EXT = 5'h13;

    localparam logic [3:0] OFS_IMR   = 4'h0;
    localparam logic [3:0] OFS_ISR   = 4'h1;
    localparam logic [3:0] OFS_IVR   = 4'h2;
    localparam logic [3:0] OFS_ACR   = 4'h3;
    localparam logic [3:0] OFS_CTR_PRESET_UPPER  = 4'h4;
    localparam logic [3:0] OFS_CTR_PRESET_LOWER  = 4'h5;
    localparam logic [3:0] OFS_CTCMD = 4'h6;
    localparam logic [3:0] OFS_CTVU  = 4'h7;
    localparam logic [3:0] OFS_CTVL  = 4'h8;
    localparam logic [3:0] OFS_SEL0  = 4'ha;
    localparam logic [3:0] OFS_DIRQ  = 4'he;

    localparam logic [7:0] RST_IMR  = 8'h00;
    localparam logic [7:0] RST_IVR  = 8'h0f;
    localparam logic [7:0] RST_ACR  = 8'h00;
    localparam logic [7:0] RST_CTU  = 8'h00;
    localparam logic [7:0] RST_CTL  = 8'h02;
    localparam logic [4:0] RST_SEL  = 5'h00;
    localparam logic [4:0] RST_DIRQ = 5'h00;

    localparam int unsigned ISR_CT_BIT  = 3;
    localparam int unsigned ACR_TMR_BIT = 4;
    localparam int unsigned ACR_EXT_BIT = 6;
    localparam int unsigned ACR_OUT_BIT = 7;
    localparam int unsigned SYNC_CS     = 0;
    localparam int unsigned SYNC_IACK   = 1;
    localparam int unsigned SYNC_EXT    = 2;
    localparam int unsigned SYNC_CTCLK  = 3;

    localparam logic [7:0] CMD_START  = 8'h01;
    localparam logic [7:0] CMD_STOP   = 8'h02;
    localparam logic [7:0] CMD_LOAD   = 8'h03;
    localparam logic [7:0] CMD_TO_ON  = 8'h04;
    localparam logic [7:0] CMD_TO_OFF = 8'h05;

    typedef enum logic [2:0] {
        DBITC_CT_IDLE = 3'b001,
        DBITC_CT_RUN  = 3'b010,
        DBITC_CT_WAIT = 3'b100
    } dbitc_ct_state_t;
endpackage

//--- hw/dbitc_core.sv
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module dbitc_core (
    input  wire logic                          core_clk,
    input  wire logic                          rst_n,
    input  wire logic [3:0]                    reg_addr,
    input  wire logic [7:0]                    reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic      [7:0]                    reg_rdata,
    input  wire logic                          chip_select_in_n,
    input  wire logic                          irq_ack_in_n,
    output logic                               data_ack_out_n,
    output logic      [7:0]                    vector_out,
    output logic                               vector_oe,
    input  wire logic [7:0]                    event_in,
    input  wire logic                          rx_char_in,
    input  wire logic                          ext_timing_in,
    input  wire logic                          ct_ext_clk_in,
    output logic                               irq_out_n,
    output logic      [4:0]                    discrete_irq_pins_o,
    output logic      [4:0]                    discrete_irq_pins_oe,
    output logic                               ct_pin_out,
    output logic      [dbitc_pkg::NUM_SEL-1:0] baud_tick_out
);
    logic [26:0]                    ref_acc_q;
    logic                           osc_tick_q;
    logic [dbitc_pkg::NUM_RATES-1:0] rate_tick;
    logic [dbitc_pkg::NUM_SYNC-1:0] sync1_q;
    logic [dbitc_pkg::NUM_SYNC-1:0] sync2_q;
    logic [dbitc_pkg::NUM_SYNC-1:0] sync3_q;
    logic [dbitc_pkg::NUM_SYNC-1:0] stable_q;
    logic [dbitc_pkg::NUM_SYNC-1:0] settle;
    logic [dbitc_pkg::NUM_SYNC-1:0] rise;
    logic [7:0]                     imr_q;
    logic [7:0]                     ivr_q;
    logic [7:0]                     acr_q;
    logic [7:0]                     ctu_q;
    logic [7:0]                     ctl_q;
    logic [4:0]                     dirq_q;
    logic [4:0]                     sel_q [dbitc_pkg::NUM_SEL];
    logic [15:0]                    count_q;
    logic [15:0]                    preset;
    dbitc_pkg::dbitc_ct_state_t     ct_state_q;
    logic                           to_mode_q;
    logic                           ct_flag_q;
    logic                           sq_q;
    logic                           ct_clk_q;
    logic                           ct_tick;
    logic                           zero_evt;
    logic                           cmd_wr;
    logic [7:0]                     irq_status_reg;
    logic                           pending;

    assign settle = ~(sync2_q ^ sync3_q);
    assign rise   = settle & sync3_q & ~stable_q;
    assign cmd_wr = reg_wr && reg_addr == dbitc_pkg::OFS_CTCMD;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q  <= '1;
            sync2_q  <= '1;
            sync3_q  <= '1;
            stable_q <= '1;
        end else begin
            sync1_q  <= {ct_ext_clk_in, ext_timing_in, irq_ack_in_n, chip_select_in_n};
            sync2_q  <= sync1_q;
            sync3_q  <= sync2_q;
            stable_q <= (settle & sync3_q) | (~settle & stable_q);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_acc_q  <= '0;
            osc_tick_q <= 1'b0;
        end else if (ref_acc_q + 27'(dbitc_pkg::REF_HZ) >= 27'(dbitc_pkg::CLK_HZ)) begin
            ref_acc_q  <= ref_acc_q + 27'(dbitc_pkg::REF_HZ) - 27'(dbitc_pkg::CLK_HZ);
            osc_tick_q <= 1'b1;
        end else begin
            ref_acc_q  <= ref_acc_q + 27'(dbitc_pkg::REF_HZ);
            osc_tick_q <= 1'b0;
        end
    end

    for (genvar i = 0; i < dbitc_pkg::NUM_RATES; i++) begin : g_rate
        logic [12:0] div_q;
        logic        tick_q;
        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                div_q  <= '0;
                tick_q <= 1'b0;
            end else if (osc_tick_q) begin
                tick_q <= div_q == dbitc_pkg::RATE_DIV[i] - 13'h0001;
                div_q  <= (div_q == dbitc_pkg::RATE_DIV[i] - 13'h0001) ? 13'h0000 : div_q + 13'h0001;
            end else begin
                tick_q <= 1'b0;
            end
        end
        assign rate_tick[i] = tick_q;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            imr_q  <= dbitc_pkg::RST_IMR;
            ivr_q  <= dbitc_pkg::RST_IVR;
            acr_q  <= dbitc_pkg::RST_ACR;
            dirq_q <= dbitc_pkg::RST_DIRQ;
        end else if (reg_wr) begin
            if (reg_addr == dbitc_pkg::OFS_IMR) begin
                imr_q <= reg_wdata;
            end
            if (reg_addr == dbitc_pkg::OFS_IVR) begin
                ivr_q <= reg_wdata;
            end
            if (reg_addr == dbitc_pkg::OFS_ACR) begin
                acr_q <= reg_wdata;
            end
            if (reg_addr == dbitc_pkg::OFS_DIRQ) begin
                dirq_q <= reg_wdata[4:0];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctu_q <= dbitc_pkg::RST_CTU;
            ctl_q <= dbitc_pkg::RST_CTL;
        end else if (reg_wr) begin
            if (reg_addr == dbitc_pkg::OFS_CTR_PRESET_UPPER) begin
                ctu_q <= reg_wdata;
            end
            if (reg_addr == dbitc_pkg::OFS_CTR_PRESET_LOWER) begin
                ctl_q <= reg_wdata;
            end
        end
    end
    assign preset = {ctu_q, ctl_q};

    // counter tick from reference or external clock
    assign ct_tick  = acr_q[dbitc_pkg::ACR_EXT_BIT] ? rise[dbitc_pkg::SYNC_CTCLK] : osc_tick_q;
    assign zero_evt = ct_state_q == dbitc_pkg::DBITC_CT_RUN && ct_tick && count_q <= 16'h0001;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ct_state_q <= dbitc_pkg::DBITC_CT_IDLE;
            count_q    <= '0;
            to_mode_q  <= 1'b0;
        end else if (cmd_wr && reg_wdata == dbitc_pkg::CMD_STOP) begin
            ct_state_q <= dbitc_pkg::DBITC_CT_IDLE;
        end else if (cmd_wr && reg_wdata == dbitc_pkg::CMD_START) begin
            ct_state_q <= dbitc_pkg::DBITC_CT_RUN;
            count_q    <= preset;
        end else if (cmd_wr && reg_wdata == dbitc_pkg::CMD_LOAD) begin
            count_q <= preset;
        end else if (cmd_wr && reg_wdata == dbitc_pkg::CMD_TO_ON) begin
            to_mode_q  <= 1'b1;
            ct_state_q <= dbitc_pkg::DBITC_CT_WAIT;
            count_q    <= preset;
        end else if (cmd_wr && reg_wdata == dbitc_pkg::CMD_TO_OFF) begin
            to_mode_q  <= 1'b0;
            ct_state_q <= dbitc_pkg::DBITC_CT_IDLE;
        end else if (to_mode_q && rx_char_in) begin
            ct_state_q <= dbitc_pkg::DBITC_CT_RUN;
            count_q    <= preset;
        end else begin
            unique case (ct_state_q)
                dbitc_pkg::DBITC_CT_IDLE: begin
                    count_q <= count_q;
                end
                dbitc_pkg::DBITC_CT_WAIT: begin
                    count_q <= count_q;
                end
                dbitc_pkg::DBITC_CT_RUN: begin
                    if (zero_evt) begin
                        count_q <= preset;
                        if (to_mode_q) begin
                            ct_state_q <= dbitc_pkg::DBITC_CT_WAIT;
                        end else if (!acr_q[dbitc_pkg::ACR_TMR_BIT]) begin
                            ct_state_q <= dbitc_pkg::DBITC_CT_IDLE;
                        end
                    end else if (ct_tick) begin
                        count_q <= count_q - 16'h0001;
                    end
                end
                default: begin
                    ct_state_q <= dbitc_pkg::DBITC_CT_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ct_flag_q <= 1'b0;
        end else if (zero_evt) begin
            ct_flag_q <= 1'b1;
        end else if (cmd_wr && reg_wdata == dbitc_pkg::CMD_STOP) begin
            ct_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sq_q     <= 1'b0;
            ct_clk_q <= 1'b0;
        end else begin
            ct_clk_q <= zero_evt && acr_q[dbitc_pkg::ACR_TMR_BIT] && !to_mode_q;
            if (zero_evt && acr_q[dbitc_pkg::ACR_TMR_BIT] && !to_mode_q) begin
                sq_q <= ~sq_q;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ct_pin_out <= 1'b0;
        end else begin
            ct_pin_out <= acr_q[dbitc_pkg::ACR_OUT_BIT] ? (to_mode_q ? ~ct_flag_q : sq_q) : 1'b0;
        end
    end

    for (genvar k = 0; k < dbitc_pkg::NUM_SEL; k++) begin : g_sel
        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                sel_q[k]         <= dbitc_pkg::RST_SEL;
                baud_tick_out[k] <= 1'b0;
            end else begin
                if (reg_wr && reg_addr == dbitc_pkg::OFS_SEL0 + 4'(k)) begin
                    sel_q[k] <= reg_wdata[4:0];
                end
                if (sel_q[k] == dbitc_pkg::SEL_CT) begin
                    baud_tick_out[k] <= ct_clk_q;
                end else if (sel_q[k] == dbitc_pkg::SEL_EXT) begin
                    baud_tick_out[k] <= rise[dbitc_pkg::SYNC_EXT];
                end else if (sel_q[k] < dbitc_pkg::SEL_CT) begin
                    baud_tick_out[k] <= rate_tick[sel_q[k]];
                end else begin
                    baud_tick_out[k] <= 1'b0;
                end
            end
        end
    end

    always_comb begin
        irq_status_reg                         = event_in;
        irq_status_reg[dbitc_pkg::ISR_CT_BIT]  = ct_flag_q;
    end
    assign pending = |(irq_status_reg & imr_q);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_out_n <= 1'b1;
        end else begin
            irq_out_n <= ~pending;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            discrete_irq_pins_o  <= '0;
            discrete_irq_pins_oe <= '0;
        end else begin
            discrete_irq_pins_o  <= '0;
            discrete_irq_pins_oe <= dirq_q & {irq_status_reg[4], irq_status_reg[0], irq_status_reg[5], irq_status_reg[1], irq_status_reg[dbitc_pkg::ISR_CT_BIT]};
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_ack_out_n <= 1'b1;
            vector_out     <= '0;
            vector_oe      <= 1'b0;
        end else if (!stable_q[dbitc_pkg::SYNC_CS]) begin
            data_ack_out_n <= 1'b0;
            vector_oe      <= 1'b0;
        end else if (!stable_q[dbitc_pkg::SYNC_IACK] && (pending || vector_oe)) begin
            data_ack_out_n <= 1'b0;
            vector_out     <= vector_oe ? vector_out : ivr_q;
            vector_oe      <= 1'b1;
        end else begin
            data_ack_out_n <= 1'b1;
            vector_oe      <= 1'b0;
        end
    end

    // Register read port, data one cycle after strobe
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (!reg_rd) begin
            reg_rdata <= '0;
        end else begin
            unique case (reg_addr)
                dbitc_pkg::OFS_IMR:  reg_rdata <= imr_q;
                dbitc_pkg::OFS_ISR:  reg_rdata <= irq_status_reg;
                dbitc_pkg::OFS_IVR:  reg_rdata <= ivr_q;
                dbitc_pkg::OFS_ACR:  reg_rdata <= acr_q;
                dbitc_pkg::OFS_CTR_PRESET_UPPER: reg_rdata <= ctu_q;
                dbitc_pkg::OFS_CTR_PRESET_LOWER: reg_rdata <= ctl_q;
                dbitc_pkg::OFS_CTVU: reg_rdata <= count_q[15:8];
                dbitc_pkg::OFS_CTVL: reg_rdata <= count_q[7:0];
                dbitc_pkg::OFS_DIRQ: reg_rdata <= {3'h0, dirq_q};
                4'ha, 4'hb, 4'hc, 4'hd: reg_rdata <= {3'h0, sel_q[reg_addr[1:0] - 2'h2]};
                default:             reg_rdata <= '0;
            endcase
        end
    end
endmodule

//--- testbench/dbitc_core_props.sv
`timescale 1ns/1ps
module dbitc_core_props (
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       chip_select_in_n,
    input wire logic       irq_ack_in_n,
    input wire logic       data_ack_out_n,
    input wire logic [7:0] vector_out,
    input wire logic       vector_oe,
    input wire logic [7:0] event_in,
    input wire logic       irq_out_n,
    input wire logic [4:0] discrete_irq_pins_oe,
    input wire logic       ct_pin_out,
    input wire logic [3:0] baud_tick_out
);
    logic [7:0] imr_q;
    logic [7:0] ivr_q;
    logic       acr7_q;
    logic       dirq1_q;

    // Shadow copies of written registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            imr_q   <= dbitc_pkg::RST_IMR;
            ivr_q   <= dbitc_pkg::RST_IVR;
            acr7_q  <= 1'b0;
            dirq1_q <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == dbitc_pkg::OFS_IMR) imr_q <= reg_wdata;
            if (reg_addr == dbitc_pkg::OFS_IVR) ivr_q <= reg_wdata;
            if (reg_addr == dbitc_pkg::OFS_ACR) acr7_q <= reg_wdata[7];
            if (reg_addr == dbitc_pkg::OFS_DIRQ) dirq1_q <= reg_wdata[1];
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence sel_held;
        !chip_select_in_n [*6];
    endsequence
    sequence no_req;
        (chip_select_in_n && irq_ack_in_n) [*6];
    endsequence
    sequence quiet_irq;
        (irq_out_n && irq_ack_in_n) [*3] ##1 irq_out_n [*6];
    endsequence

    irq_assert_a: assert property ((|(event_in & imr_q & 8'hf7)) [*4] |-> !irq_out_n)
        else $error("irq not asserted for enabled event");
    irq_release_a: assert property ((((event_in & imr_q) == 8'h00) && !imr_q[3]) [*4] |-> irq_out_n)
        else $error("irq held with nothing enabled");
    rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    rd_ivr_a: assert property (reg_rd && reg_addr == dbitc_pkg::OFS_IVR |=> reg_rdata == ivr_q)
        else $error("vector register readback wrong");
    rd_imr_a: assert property (reg_rd && reg_addr == dbitc_pkg::OFS_IMR |=> reg_rdata == imr_q)
        else $error("mask register readback wrong");
    ack_sel_a: assert property (sel_held |-> !data_ack_out_n)
        else $error("no acknowledge for held select");
    ack_drop_a: assert property (no_req |-> data_ack_out_n)
        else $error("acknowledge without request");
    vec_drive_a: assert property (vector_oe |-> vector_out == ivr_q && !data_ack_out_n)
        else $error("vector driven wrong");
    vec_refuse_a: assert property (quiet_irq |-> !vector_oe)
        else $error("vector driven with nothing pending");
    dpin_rx_a: assert property ((dirq1_q && event_in[1]) [*4] |-> discrete_irq_pins_oe[1])
        else $error("discrete pin not pulled");
    ctpin_off_a: assert property (!acr7_q && !$past(acr7_q) |-> !ct_pin_out)
        else $error("counter pin active while deselected");
    tick_pulse_a: assert property (baud_tick_out[0] |=> !baud_tick_out[0])
        else $error("tick longer than one cycle");
endmodule

bind dbitc_core dbitc_core_props u_props (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chip_select_in_n(chip_select_in_n), .irq_ack_in_n(irq_ack_in_n),
    .data_ack_out_n(data_ack_out_n), .vector_out(vector_out), .vector_oe(vector_oe), .event_in(event_in),
    .irq_out_n(irq_out_n), .discrete_irq_pins_oe(discrete_irq_pins_oe), .ct_pin_out(ct_pin_out),
    .baud_tick_out(baud_tick_out)
);

//--- testbench/dbitc_host_model.sv
`timescale 1ns/1ps
module dbitc_host_model (
    input  wire logic       core_clk,
    output logic            chip_select_in_n,
    output logic            irq_ack_in_n,
    input  wire logic       data_ack_out_n,
    input  wire logic [7:0] vector_out,
    input  wire logic       vector_oe
);
    initial begin
        chip_select_in_n = 1'b1;
        irq_ack_in_n     = 1'b1;
    end

    // Pin cycle; extra hold makes a slow host
    task automatic pin_cycle(input logic iack, input int hold, output logic acked, output logic [7:0] vec);
        acked = 1'b0;
        vec   = 8'h00;
        @(posedge core_clk);
        if (iack) begin
            irq_ack_in_n <= 1'b0;
        end else begin
            chip_select_in_n <= 1'b0;
        end
        for (int i = 0; i < 28 + hold; i++) begin
            @(posedge core_clk);
            if (!acked && data_ack_out_n === 1'b0) begin
                acked = 1'b1;
                vec   = vector_oe === 1'b1 ? vector_out : 8'h00;
            end
        end
        chip_select_in_n <= 1'b1;
        irq_ack_in_n     <= 1'b1;
        for (int i = 0; i < 10 && data_ack_out_n !== 1'b1; i++) begin
            @(posedge core_clk);
        end
    endtask
endmodule

//--- testbench/tb.sv
`timescale 1ns/1ps
module tb;
    logic                          core_clk = 1'b0;
    logic                          rst_n = 1'b0;
    logic [3:0]                    reg_addr = 4'h0;
    logic [7:0]                    reg_wdata = 8'h00;
    logic                          reg_wr = 1'b0;
    logic                          reg_rd = 1'b0;
    logic [7:0]                    reg_rdata;
    logic                          chip_select_in_n;
    logic                          irq_ack_in_n;
    logic                          data_ack_out_n;
    logic [7:0]                    vector_out;
    logic                          vector_oe;
    logic [7:0]                    event_in = 8'h00;
    logic                          rx_char_in = 1'b0;
    logic                          ext_timing_in = 1'b0;
    logic                          irq_out_n;
    logic [4:0]                    pins_o;
    logic [4:0]                    pins_oe;
    logic                          ct_pin_out;
    logic [dbitc_pkg::NUM_SEL-1:0] baud_tick_out;
    int                            fail_count = 0;
    int                            compares = 0;

    always #5 core_clk = ~core_clk;

    dbitc_core DUT (
        .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chip_select_in_n(chip_select_in_n),
        .irq_ack_in_n(irq_ack_in_n), .data_ack_out_n(data_ack_out_n), .vector_out(vector_out),
        .vector_oe(vector_oe), .event_in(event_in), .rx_char_in(rx_char_in), .ext_timing_in(ext_timing_in),
        .ct_ext_clk_in(1'b0), .irq_out_n(irq_out_n), .discrete_irq_pins_o(pins_o),
        .discrete_irq_pins_oe(pins_oe), .ct_pin_out(ct_pin_out), .baud_tick_out(baud_tick_out));

    dbitc_host_model host (
        .core_clk(core_clk), .chip_select_in_n(chip_select_in_n), .irq_ack_in_n(irq_ack_in_n),
        .data_ack_out_n(data_ack_out_n), .vector_out(vector_out), .vector_oe(vector_oe));

    task automatic wrap_up();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
        d = reg_rdata;
    endtask

    task automatic cmd(input logic [7:0] c);
        wr(dbitc_pkg::OFS_CTCMD, c);
        repeat (90) @(posedge core_clk);
    endtask

    task automatic t_reset();
        logic [7:0] d;
        logic [3:0] a;
        for (int i = 0; i < 16; i++) begin
            a = 4'(i);
            if (i < 6 || i > 8) begin
                rd(a, d);
                chk(d, a == dbitc_pkg::OFS_IVR ? 8'h0f : a == dbitc_pkg::OFS_CTR_PRESET_LOWER ? 8'h02 : 8'h00, "reset");
            end
        end
        chk({irq_out_n, data_ack_out_n, vector_oe}, 16'h6, "idle pins");
    endtask

    task automatic t_irq();
        logic [7:0] d;
        event_in <= 8'h04;
        wr(dbitc_pkg::OFS_IMR, 8'h02);
        repeat (8) @(posedge core_clk);
        chk(irq_out_n, 1'b1, "masked event");
        rd(dbitc_pkg::OFS_ISR, d);
        chk(d, 8'h04, "status masked");
        event_in <= 8'h06;
        repeat (8) @(posedge core_clk);
        chk(irq_out_n, 1'b0, "enabled event");
        rd(dbitc_pkg::OFS_ISR, d);
        chk(d, 8'h06, "status both");
    endtask

    task automatic t_vec();
        logic       ok;
        logic [7:0] v;
        wr(dbitc_pkg::OFS_IVR, 8'h5a);
        wr(dbitc_pkg::OFS_DIRQ, 8'h02);
        host.pin_cycle(1'b1, 0, ok, v);
        chk({ok, v}, 16'h15a, "vector cycle");
        chk(pins_oe, 5'h02, "discrete rx pin");
        host.pin_cycle(1'b0, 5, ok, v);
        chk(ok, 1'b1, "select ack");
        event_in <= 8'h00;
        repeat (8) @(posedge core_clk);
        chk({irq_out_n, pins_oe}, 16'h20, "released");
        host.pin_cycle(1'b1, 0, ok, v);
        chk(ok, 1'b0, "no pending no ack");
    endtask

    task automatic t_count();
        logic [7:0] d;
        int         n;
        wr(dbitc_pkg::OFS_IMR, 8'h08);
        wr(dbitc_pkg::OFS_CTR_PRESET_LOWER, 8'h03);
        cmd(dbitc_pkg::CMD_LOAD);
        wr(dbitc_pkg::OFS_CTCMD, dbitc_pkg::CMD_START);
        for (n = 0; n < 300 && irq_out_n !== 1'b0; n++) begin
            @(posedge core_clk);
        end
        chk(16'(n >= 45 && n <= 120), 16'h1, "one shot delay");
        rd(dbitc_pkg::OFS_ISR, d);
        chk(d[3], 1'b1, "counter flag");
        repeat (90) @(posedge core_clk);
        cmd(dbitc_pkg::CMD_STOP);
        chk(irq_out_n, 1'b1, "stop clears");
    endtask

    task automatic t_timer();
        logic [7:0] d;
        logic       prev;
        int         tog;
        int         n [3];
        wr(dbitc_pkg::OFS_ACR, 8'h90);
        wr(dbitc_pkg::OFS_SEL0, {3'h0, dbitc_pkg::SEL_CT});
        wr(dbitc_pkg::OFS_SEL0 + 4'h1, 8'h11);
        wr(dbitc_pkg::OFS_SEL0 + 4'h2, {3'h0, dbitc_pkg::SEL_EXT});
        cmd(dbitc_pkg::CMD_START);
        tog = 0;
        n = '{0, 0, 0};
        prev = ct_pin_out;
        for (int i = 0; i < 651; i++) begin
            @(posedge core_clk);
            ext_timing_in <= (i % 80) < 40;
            tog += int'(ct_pin_out !== prev);
            prev = ct_pin_out;
            for (int s = 0; s < 3; s++) n[s] += int'(baud_tick_out[s] === 1'b1);
        end
        chk(16'(tog >= 6 && tog <= 10), 16'h1, "square wave");
        chk(16'(n[0] >= 7 && n[0] <= 9), 16'h1, "counter clock");
        chk(16'(n[1] >= 3 && n[1] <= 5), 16'h1, "fast rate");
        chk(16'(n[2] >= 7 && n[2] <= 9), 16'h1, "ext timing");
        rd(dbitc_pkg::OFS_CTVU, d);
        chk(d, 8'h00, "value upper");
        rd(dbitc_pkg::OFS_CTVL, d);
        chk(16'(d <= 8'h03), 16'h1, "value lower");
        cmd(dbitc_pkg::CMD_STOP);
    endtask

    task automatic t_tmo();
        int hits;
        int n;
        wr(dbitc_pkg::OFS_ACR, 8'h00);
        cmd(dbitc_pkg::CMD_TO_ON);
        hits = 0;
        for (int i = 0; i < 272; i++) begin
            @(posedge core_clk);
            rx_char_in <= (i % 30) == 0;
            hits += int'(irq_out_n !== 1'b1);
        end
        chk(16'(hits), 16'h0, "no pause yet");
        for (n = 0; n < 200 && irq_out_n !== 1'b0; n++) begin
            @(posedge core_clk);
        end
        chk(16'(n >= 40 && n <= 120), 16'h1, "pause signalled");
        cmd(dbitc_pkg::CMD_TO_OFF);
        cmd(dbitc_pkg::CMD_STOP);
        chk(irq_out_n, 1'b1, "stop after pause");
    endtask

    initial begin
        repeat (10000) @(posedge core_clk);
        fail_count++;
        wrap_up();
    end

    initial begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset();
        t_irq();
        t_vec();
        t_count();
        t_timer();
        t_tmo();
        wrap_up();
    end
endmodule
